// File: pxb_crossbar.v
// Priority pin crossbar and port pin control for four 8-bit ports.
// Assumes software reaches the registers through the write and read ports,
// peripherals sit on the slot vectors and the pads on the pin vectors.
//
// Operation
// RULE1: Pins allocated upward from first pin onward.
// RULE2: Peripherals served in fixed priority order.
// RULE3: Only enabled peripherals reach any pin.
// RULE4: Serial A always owns pins zero and one.
// RULE5: Two-wire, capcomp, irq A, irq B follow.
// RULE6: A peripheral's signals are allocated together.
// RULE7: SPI select pin only in four-wire mode.
// RULE8: Unallocated pins are byte/bit addressable GPIO.
// RULE9: Peripheral drives allocated pins, data writes ignored.
// RULE10: Normal read returns sensed pin level.
// RULE11: Read-modify-write read returns stored latch.
// RULE12: Drivers off until crossbar enable set.
// RULE13: Peripheral input pins have drivers forced off.
// RULE14: Push-pull drives both levels; open-drain only low.
// RULE15: Mode bit one push-pull; reset open-drain.
// RULE16: Two-wire and mode-0 receive always open-drain.
// RULE17: Software makes digital inputs open-drain, data one.
// RULE18: Pull-ups on, global disable, off when driving low.
// RULE19: Input-mode zero on ports 1, 2 means analog.
// RULE20: Analog reads zero, no pull-up, skipped.
// RULE21: Software parks analog pins open-drain with one.
// RULE22: Software configures crossbar first, then leaves it.
// RULE23: Allocation recomputed continuously from configuration.
// RULE24: Pin reads pass two synchroniser stages.
`timescale 1ns/1ps
`default_nettype none
`include "pxb_map.vh"

module pxb_crossbar
(
	// Clock and reset
	input  wire        clk_in,
	input  wire        reset_n_in,
	// Register write
	input  wire        wr_en_in,
	input  wire [3:0]  wr_target_in,
	input  wire [7:0]  wr_mask_in,
	input  wire [7:0]  wr_data_in,
	// Register read
	input  wire        rd_en_in,
	input  wire [3:0]  rd_target_in,
	input  wire        rd_rmw_in,
	output wire [7:0]  rd_data_out,
	output wire        rd_valid_out,
	// Peripheral side
	input  wire [18:0] periph_out_in,
	input  wire [18:0] periph_drive_in,
	input  wire        spi_four_wire_in,
	input  wire        serial_a_mode0_in,
	input  wire        serial_b_mode0_in,
	input  wire        small_package_in,
	output wire [18:0] periph_in_out,
	output wire [18:0] route_active_out,
	// Pads
	input  wire [31:0] pin_level_in,
	output wire [31:0] pin_out_out,
	output wire [31:0] pin_oe_out,
	output wire [31:0] pin_pullup_out
);

	// ************************************************************
	// Software registers
	// ************************************************************
	reg  [31:0] data_latch_reg;    // Port data latches, four bytes.
	reg  [31:0] data_latch_next;
	reg  [31:0] out_mode_reg;      // Output mode, one bit per pin.
	reg  [31:0] out_mode_next;
	reg  [15:0] in_mode_reg;       // Input mode for ports 1 and 2.
	reg  [15:0] in_mode_next;
	reg  [31:0] cfg_reg;           // Crossbar configuration bytes 0 to 3.
	reg  [31:0] cfg_next;

	// Byte slices of the configuration for readability.
	wire [7:0]  xbar_cfg_0 = cfg_reg[7:0];
	wire [7:0]  xbar_cfg_1 = cfg_reg[15:8];
	wire [7:0]  xbar_cfg_2 = cfg_reg[23:16];
	wire [7:0]  xbar_cfg_3 = cfg_reg[31:24];

	wire        crossbar_enable_bit = xbar_cfg_2[`PXB_CFG2_XBAR_EN];
	wire        pullup_disable_bit  = xbar_cfg_2[`PXB_CFG2_PU_DIS];
	wire        serial_a_route_enable  = xbar_cfg_0[`PXB_CFG0_SER_A_EN];
	wire        spi_route_enable       = xbar_cfg_0[`PXB_CFG0_SPI_EN];
	wire        twowire_route_enable   = xbar_cfg_0[`PXB_CFG0_TW_EN];
	wire        serial_b_route_enable  = xbar_cfg_2[`PXB_CFG2_SER_B_EN];
	wire [2:0]  capcomp_route_count    = xbar_cfg_0[`PXB_CFG0_CAPCOMP_LSB +: 3];
	wire        ext_irq_a_route_enable = xbar_cfg_1[`PXB_CFG1_IRQ_A_EN];
	wire        ext_irq_b_route_enable = xbar_cfg_1[`PXB_CFG1_IRQ_B_EN];
	wire        conv_b_route_enable    = xbar_cfg_3[`PXB_CFG3_CONV_B_EN];

	// Write decode: upper two target bits pick the bank, lower two the port.
	wire [1:0]  wr_bank = wr_target_in[3:2];
	wire [1:0]  wr_port = wr_target_in[1:0];

	// Masked writes serve both whole-byte and single-bit stores; a bit store
	// keeps the other latch bits, which is what a bitwise move expects.
	always @*
	begin
		data_latch_next = data_latch_reg;
		out_mode_next   = out_mode_reg;
		in_mode_next    = in_mode_reg;
		cfg_next        = cfg_reg;
		if (wr_en_in)
		begin
			case (wr_bank)
				`PXB_BANK_DATA:
					// Latches always store; on allocated pins they just do not
					// reach the pad.  // see RULE8 // see RULE9
					data_latch_next[wr_port * 8 +: 8] =
						(data_latch_reg[wr_port * 8 +: 8] & ~wr_mask_in) | (wr_data_in & wr_mask_in);
				`PXB_BANK_OUT_MODE:
					out_mode_next[wr_port * 8 +: 8] =
						(out_mode_reg[wr_port * 8 +: 8] & ~wr_mask_in) | (wr_data_in & wr_mask_in);
				`PXB_BANK_IN_MODE:
				begin
					// Only ports 1 and 2 carry an input-mode register.
					if (wr_port == `PXB_IN_MODE_PORT1)
						in_mode_next[7:0] = (in_mode_reg[7:0] & ~wr_mask_in) | (wr_data_in & wr_mask_in);
					else if (wr_port == `PXB_IN_MODE_PORT2)
						in_mode_next[15:8] = (in_mode_reg[15:8] & ~wr_mask_in) | (wr_data_in & wr_mask_in);
				end
				default:
					cfg_next[wr_port * 8 +: 8] =
						(cfg_reg[wr_port * 8 +: 8] & ~wr_mask_in) | (wr_data_in & wr_mask_in);
			endcase
		end
	end

	// Register storage; reset leaves every pin open-drain and digital, and
	// the crossbar switched off.
	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			data_latch_reg <= `PXB_DATA_RST;
			out_mode_reg   <= `PXB_OUT_MODE_RST;   // see RULE15
			in_mode_reg    <= `PXB_IN_MODE_RST;    // see RULE19
			cfg_reg        <= `PXB_CFG_RST;
		end
		else
		begin
			data_latch_reg <= data_latch_next;
			out_mode_reg   <= out_mode_next;
			in_mode_reg    <= in_mode_next;
			cfg_reg        <= cfg_next;
		end
	end

	// ************************************************************
	// Pin sensing
	// ************************************************************
	wire [31:0] pin_sync;     // Pad levels after two stages.
	wire [31:0] analog_pin;   // Pins set as analog inputs.
	wire [31:0] pin_digital;  // Digital input path, zero on analog pins.

	// Pad levels are resampled before any logic reads them.  // see RULE24
	pxb_sync2 u_sync
	(
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.async_in   (pin_level_in),
		.sync_out   (pin_sync)
	);

	// A zero input-mode bit on port 1 or 2 marks an analog pin.  // see RULE19
	assign analog_pin  = {8'h00, ~in_mode_reg, 8'h00};
	assign pin_digital = pin_sync & ~analog_pin;   // see RULE20

	// ************************************************************
	// Allocation
	// ************************************************************
	reg  [18:0]  slot_en;     // Slots requesting a pin.
	wire [31:0]  pin_hit;     // Pin carries a peripheral signal.
	wire [159:0] pin_slot;    // Slot number per pin.
	wire [5:0]   pin_limit;   // Pins that exist on this package.
	integer      c;

	// Whole peripherals enable all their slots at once, SPI select only in four-wire
	// mode; capcomp outputs enable a count from the lowest.  // see RULE3 // see RULE6
	always @*
	begin
		slot_en = 19'h0_0000;
		slot_en[`PXB_SLOT_SER_A_TX]  = serial_a_route_enable;   // see RULE4
		slot_en[`PXB_SLOT_SER_A_RX]  = serial_a_route_enable;
		slot_en[`PXB_SLOT_SPI_SCK]   = spi_route_enable;
		slot_en[`PXB_SLOT_SPI_MISO]  = spi_route_enable;
		slot_en[`PXB_SLOT_SPI_MOSI]  = spi_route_enable;
		slot_en[`PXB_SLOT_SPI_SEL]   = spi_route_enable & spi_four_wire_in;   // see RULE7
		slot_en[`PXB_SLOT_TW_DATA]   = twowire_route_enable;   // see RULE5
		slot_en[`PXB_SLOT_TW_CLOCK]  = twowire_route_enable;
		slot_en[`PXB_SLOT_SER_B_TX]  = serial_b_route_enable;
		slot_en[`PXB_SLOT_SER_B_RX]  = serial_b_route_enable;
		for (c = 0; c < `PXB_NUM_CAPCOMP; c = c + 1)
		begin
			slot_en[`PXB_SLOT_CAPCOMP + c] = (c < capcomp_route_count);
		end
		slot_en[`PXB_SLOT_IRQ_A]     = ext_irq_a_route_enable;
		slot_en[`PXB_SLOT_IRQ_B]     = ext_irq_b_route_enable;
		slot_en[`PXB_SLOT_CONV_B]    = conv_b_route_enable;
	end

	// The smaller package stops after port 2.  // see RULE1
	assign pin_limit = small_package_in ? `PXB_LIMIT_SMALL : `PXB_LIMIT_FULL;

	// Slots in priority order take pins upward, skipping analog pins, and
	// the map follows configuration changes at once.  // see RULE2 // see RULE23
	pxb_alloc u_alloc
	(
		.slot_en_in   (slot_en),
		.skip_in      (analog_pin),    // see RULE20
		.pin_limit_in (pin_limit),
		.pin_hit_out  (pin_hit),
		.pin_slot_out (pin_slot)
	);

	// ************************************************************
	// Pin drive
	// ************************************************************
	wire [18:0] input_only;   // Slots that never drive.
	wire [18:0] force_od;     // Slots held to open-drain.
	wire [31:0] out_next;
	wire [31:0] oe_next;
	wire [31:0] pullup_next;

	// Receive pins in mode 0 may drive, but only open-drain.  // see RULE13
	assign input_only = `PXB_INPUT_ONLY
		& ~({18'h0_0000, serial_a_mode0_in} << `PXB_SLOT_SER_A_RX)
		& ~({18'h0_0000, serial_b_mode0_in} << `PXB_SLOT_SER_B_RX);

	// Two-wire lines always, receive pins in mode 0.  // see RULE16
	assign force_od = ({18'h0_0000, 1'b1} << `PXB_SLOT_TW_DATA)
		| ({18'h0_0000, 1'b1} << `PXB_SLOT_TW_CLOCK)
		| ({18'h0_0000, serial_a_mode0_in} << `PXB_SLOT_SER_A_RX)
		| ({18'h0_0000, serial_b_mode0_in} << `PXB_SLOT_SER_B_RX);

	genvar i;
	generate
		for (i = 0; i < `PXB_NUM_PINS; i = i + 1)
		begin : g_pin
			wire [4:0] slot  = pin_slot[i * 5 +: 5];
			// Allocated pins take the peripheral's value, others the latch.
			wire       value = pin_hit[i] ? periph_out_in[slot] : data_latch_reg[i];   // see RULE9
			// Allocated input_only slots never drive, so mode-0 receive pins may; GPIO always may.
			wire       drive = pin_hit[i] ? (periph_drive_in[slot] & ~input_only[slot]) : 1'b1;   // see RULE13
			// Output mode applies to both kinds except the forced slots.
			wire       push  = out_mode_reg[i] & ~(pin_hit[i] & force_od[slot]);   // see RULE16
			// Push-pull drives both levels, open-drain only a low; nothing
			// drives until the crossbar is enabled.  // see RULE14 // see RULE12
			assign oe_next[i]     = crossbar_enable_bit & drive & (push | ~value);
			assign out_next[i]    = value;
			// Pull-up unless disabled, analog or driving low.  // see RULE18
			assign pullup_next[i] = ~pullup_disable_bit & ~analog_pin[i] & ~(oe_next[i] & ~value);
		end
	endgenerate

	// ************************************************************
	// Peripheral inputs and routing status
	// ************************************************************
	reg  [18:0] periph_in_next;
	reg  [18:0] route_next;
	integer     p;

	// Each placed slot hears its pin; unplaced slots see the idle level.
	always @*
	begin
		periph_in_next = {`PXB_NUM_SLOTS{`PXB_PERIPH_IDLE}};
		route_next     = 19'h0_0000;
		for (p = 0; p < `PXB_NUM_PINS; p = p + 1)
		begin
			if (pin_hit[p])
			begin
				periph_in_next[pin_slot[p * 5 +: 5]] = pin_digital[p];
				route_next[pin_slot[p * 5 +: 5]]     = 1'b1;
			end
		end
	end

	// ************************************************************
	// Register read
	// ************************************************************
	reg  [7:0]  rd_data_next;
	wire [1:0]  rd_bank = rd_target_in[3:2];
	wire [1:0]  rd_port = rd_target_in[1:0];

	// Data reads return the pad unless the read is the first half of a
	// read-modify-write, which wants the latch.  // see RULE10 // see RULE11
	always @*
	begin
		rd_data_next = 8'h00;
		case (rd_bank)
			`PXB_BANK_DATA:
				rd_data_next = rd_rmw_in ? data_latch_reg[rd_port * 8 +: 8] : pin_digital[rd_port * 8 +: 8];
			`PXB_BANK_OUT_MODE:
				rd_data_next = out_mode_reg[rd_port * 8 +: 8];
			`PXB_BANK_IN_MODE:
			begin
				// Ports without an input-mode register read zero.
				if (rd_port == `PXB_IN_MODE_PORT1)
					rd_data_next = in_mode_reg[7:0];
				else if (rd_port == `PXB_IN_MODE_PORT2)
					rd_data_next = in_mode_reg[15:8];
			end
			default:
				rd_data_next = cfg_reg[rd_port * 8 +: 8];
		endcase
	end

	// ************************************************************
	// Output registers
	// ************************************************************
	reg  [7:0]  rd_data_reg;
	reg         rd_valid_reg;
	reg  [18:0] periph_in_reg;
	reg  [18:0] route_reg;
	reg  [31:0] pin_out_reg;
	reg  [31:0] pin_oe_reg;
	reg  [31:0] pin_pullup_reg;

	// Every top output leaves a flip-flop; reset keeps all drivers off.
	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rd_data_reg    <= 8'h00;
			rd_valid_reg   <= 1'b0;
			periph_in_reg  <= {`PXB_NUM_SLOTS{`PXB_PERIPH_IDLE}};
			route_reg      <= 19'h0_0000;
			pin_out_reg    <= `PXB_DATA_RST;
			pin_oe_reg     <= 32'h0000_0000;   // see RULE12
			pin_pullup_reg <= 32'hFFFF_FFFF;   // see RULE18
		end
		else
		begin
			rd_data_reg    <= rd_en_in ? rd_data_next : rd_data_reg;
			rd_valid_reg   <= rd_en_in;
			periph_in_reg  <= periph_in_next;
			route_reg      <= route_next;
			pin_out_reg    <= out_next;
			pin_oe_reg     <= oe_next;
			pin_pullup_reg <= pullup_next;
		end
	end

	assign rd_data_out      = rd_data_reg;
	assign rd_valid_out     = rd_valid_reg;
	assign periph_in_out    = periph_in_reg;
	assign route_active_out = route_reg;
	assign pin_out_out      = pin_out_reg;
	assign pin_oe_out       = pin_oe_reg;
	assign pin_pullup_out   = pin_pullup_reg;

endmodule // pxb_crossbar
`default_nettype wire

// File: pxb_map.vh
// Constants for the priority pin crossbar: slot numbering, configuration bit
// positions, register targets and reset values.
// Assumes it is included by bare name from every design file that needs it.
`ifndef PXB_MAP_VH
`define PXB_MAP_VH

// ************************************************************
// Sizes
// ************************************************************
`define PXB_NUM_PINS        32
`define PXB_NUM_SLOTS       19
`define PXB_SLOT_BITS       5
`define PXB_LIMIT_FULL      6'h20
`define PXB_LIMIT_SMALL     6'h18

// ************************************************************
// Signal slots in fixed priority order, highest first
// ************************************************************
`define PXB_SLOT_SER_A_TX   0
`define PXB_SLOT_SER_A_RX   1
`define PXB_SLOT_SPI_SCK    2
`define PXB_SLOT_SPI_MISO   3
`define PXB_SLOT_SPI_MOSI   4
`define PXB_SLOT_SPI_SEL    5
`define PXB_SLOT_TW_DATA    6
`define PXB_SLOT_TW_CLOCK   7
`define PXB_SLOT_SER_B_TX   8
`define PXB_SLOT_SER_B_RX   9
`define PXB_SLOT_CAPCOMP    10
`define PXB_NUM_CAPCOMP     6
`define PXB_SLOT_IRQ_A      16
`define PXB_SLOT_IRQ_B      17
`define PXB_SLOT_CONV_B     18
`define PXB_INPUT_ONLY      19'h7_0202

// ************************************************************
// Crossbar configuration bit positions
// ************************************************************
`define PXB_CFG0_TW_EN      0
`define PXB_CFG0_SPI_EN     1
`define PXB_CFG0_SER_A_EN   2
`define PXB_CFG0_CAPCOMP_LSB 3
`define PXB_CFG1_IRQ_A_EN   2
`define PXB_CFG1_IRQ_B_EN   4
`define PXB_CFG2_SER_B_EN   2
`define PXB_CFG2_XBAR_EN    4
`define PXB_CFG2_PU_DIS     7
`define PXB_CFG3_CONV_B_EN  7

// ************************************************************
// Register targets (upper two bits pick the bank)
// ************************************************************
`define PXB_BANK_DATA       2'h0
`define PXB_BANK_OUT_MODE   2'h1
`define PXB_BANK_IN_MODE    2'h2
`define PXB_BANK_CFG        2'h3
`define PXB_IN_MODE_PORT1   2'h1
`define PXB_IN_MODE_PORT2   2'h2

// ************************************************************
// Reset values
// ************************************************************
`define PXB_DATA_RST        32'hFFFF_FFFF
`define PXB_OUT_MODE_RST    32'h0000_0000
`define PXB_IN_MODE_RST     16'hFFFF
`define PXB_CFG_RST         32'h0000_0000
`define PXB_SYNC_RST        32'h0000_0000
`define PXB_PERIPH_IDLE     1'b1

`endif

// File: pxb_sync2.v
// Two-stage synchroniser for the sensed pin levels.
// Assumes the inputs come straight from pads, outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "pxb_map.vh"

module pxb_sync2
(
	// Clock and reset
	input  wire        clk_in,
	input  wire        reset_n_in,
	// Levels in and out
	input  wire [31:0] async_in,
	output wire [31:0] sync_out
);

	// ************************************************************
	// Synchroniser stages
	// ************************************************************
	reg [31:0] stage1_reg;   // First stage, read only by the second.
	reg [31:0] stage2_reg;   // Second stage, safe for logic.

	// Both stages load every edge; the first is never looked at elsewhere.
	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			stage1_reg <= `PXB_SYNC_RST;
			stage2_reg <= `PXB_SYNC_RST;
		end
		else
		begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
		end
	end

	assign sync_out = stage2_reg;

endmodule // pxb_sync2
`default_nettype wire

// File: pxb_alloc.v
// Combinational pin allocator: walks the signal slots in priority order and
// hands each enabled one the next pin that is not skipped.
// Assumes enables and skip flags are stable registers on the caller's clock.
`timescale 1ns/1ps
`default_nettype none
`include "pxb_map.vh"

module pxb_alloc
(
	// Requests
	input  wire [18:0]  slot_en_in,
	input  wire [31:0]  skip_in,
	input  wire [5:0]   pin_limit_in,
	// Allocation
	output reg  [31:0]  pin_hit_out,
	output reg  [159:0] pin_slot_out
);

	// ************************************************************
	// Allocation walk
	// ************************************************************
	integer   s;     // Slot being placed.
	integer   k;     // Bound on skip steps.
	reg [5:0] ptr;   // Next candidate pin.

	// Each enabled slot skips analog pins, then takes the pin under ptr.
	always @*
	begin
		ptr          = 6'h00;
		pin_hit_out  = 32'h0000_0000;
		pin_slot_out = 160'h0;
		for (s = 0; s < `PXB_NUM_SLOTS; s = s + 1)
		begin
			if (slot_en_in[s])
			begin
				// Pins set as analog inputs are passed over.
				for (k = 0; k < `PXB_NUM_PINS; k = k + 1)
				begin
					if ((ptr < pin_limit_in) && skip_in[ptr[4:0]])
						ptr = ptr + 6'h01;
				end
				// Pins run out at the package limit; later slots stay unplaced.
				if (ptr < pin_limit_in)
				begin
					pin_hit_out[ptr[4:0]]          = 1'b1;
					pin_slot_out[ptr[4:0] * 5 +: 5] = s[4:0];
					ptr                            = ptr + 6'h01;
				end
			end
		end
	end

endmodule // pxb_alloc
`default_nettype wire

// File: pxb_crossbar_checker.sv
// Concurrent checks on the crossbar ports.
// Assumes one clock, async active-low reset, bound from the bench.
`timescale 1ns/1ps
`default_nettype none
module pxb_crossbar_checker
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	// Register ports
	input  wire logic        wr_en_in,
	input  wire logic [3:0]  wr_target_in,
	input  wire logic [7:0]  wr_mask_in,
	input  wire logic [7:0]  wr_data_in,
	input  wire logic        rd_en_in,
	input  wire logic [3:0]  rd_target_in,
	input  wire logic [7:0]  rd_data_out,
	input  wire logic        rd_valid_out,
	// Peripheral and pad ports
	input  wire logic [18:0] periph_out_in,
	input  wire logic        spi_four_wire_in,
	input  wire logic        serial_a_mode0_in,
	input  wire logic [18:0] periph_in_out,
	input  wire logic [18:0] route_active_out,
	input  wire logic [31:0] pin_out_out,
	input  wire logic [31:0] pin_oe_out
);
	// Shadow of the crossbar enable bit.
	logic xen_reg;
	wire  xen_next = (wr_en_in && wr_target_in == 4'hE && wr_mask_in[4]) ? wr_data_in[4] : xen_reg;
	always @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			xen_reg <= 1'b0;
		else
			xen_reg <= xen_next;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	a_drivers_off: assert property (!$past(xen_reg) |-> pin_oe_out == 32'h0000_0000)
		else $error("Driver on while disabled");
	a_input_undriven: assert property (route_active_out[1] && !$past(serial_a_mode0_in) |-> !pin_oe_out[1])
		else $error("Receive pin driven");
	a_signals_together: assert property (&route_active_out[1:0] == |route_active_out[1:0]
		&& &route_active_out[4:2] == |route_active_out[4:2] && &route_active_out[7:6] == |route_active_out[7:6]
		&& &route_active_out[9:8] == |route_active_out[9:8])
		else $error("Signals routed apart");
	a_select_four: assert property (route_active_out[5] |-> route_active_out[2] && $past(spi_four_wire_in))
		else $error("Select outside four-wire");
	a_unplaced_idle: assert property ((~route_active_out & ~periph_in_out) == 19'h0_0000)
		else $error("Unplaced slot not idle");
	a_serial_pin_zero: assert property (route_active_out[0] |-> pin_out_out[0] == $past(periph_out_in[0]))
		else $error("Transmit off pin zero");
	a_refused_read: assert property (rd_en_in && rd_target_in[3:2] == 2'h2 && rd_target_in[1:0] inside {2'h0, 2'h3}
		|=> rd_valid_out && rd_data_out == 8'h00)
		else $error("Refused read nonzero");
	a_read_answer: assert property (rd_en_in |=> rd_valid_out ##1 !rd_valid_out || $past(rd_en_in))
		else $error("Read answer wrong");
	// Main scenarios reached.
	c_four_wire: cover property (route_active_out[5]);
	c_rx_mode0: cover property (serial_a_mode0_in && route_active_out[1] && pin_oe_out[1]);
	c_refused: cover property (rd_en_in && rd_target_in == 4'h8);
endmodule // pxb_crossbar_checker
`default_nettype wire

// File: pxb_far_side.sv
// Pad model: resolves each pin from block, board and pull-up.
// Assumes board drivers only act on pins the block has released.
`timescale 1ns/1ps
`default_nettype none
module pxb_far_side
(
	// Clock for the floating pattern
	input  wire logic        clk_in,
	// Block drivers
	input  wire logic [31:0] pin_out_in,
	input  wire logic [31:0] pin_oe_in,
	input  wire logic [31:0] pin_pullup_in,
	// Board drivers
	input  wire logic [31:0] ext_en_in,
	input  wire logic [31:0] ext_val_in,
	// Resolved levels
	output logic      [31:0] level_out
);
	// A floating pin toggles so no stale level passes.
	logic [31:0] float_reg = 32'h0000_0000;
	always @(posedge clk_in)
		float_reg <= ~float_reg;
	// Released pins go to the board, else the pull-up.
	assign level_out = (pin_oe_in & pin_out_in)
		| (~pin_oe_in & ((ext_en_in & ext_val_in) | (~ext_en_in & (pin_pullup_in | float_reg))));
endmodule // pxb_far_side
`default_nettype wire

// File: pxb_crossbar_tb.sv
// Self-checking crossbar bench.
// Assumes the pad model and the checker bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module pxb_crossbar_tb;
	// One allocation case and its expected pins.
	typedef struct packed {logic [7:0] c0, c1, c2, i1, i2; logic fw; logic [18:0] rt; logic [31:0] ip, op;} pxb_row_t;
	logic        clk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic        wr_en_in = 1'b0;
	logic [3:0]  wr_target_in = 4'h0;
	logic [7:0]  wr_mask_in = 8'h00;
	logic [7:0]  wr_data_in = 8'h00;
	logic        rd_en_in = 1'b0;
	logic [3:0]  rd_target_in = 4'h0;
	logic        rd_rmw_in = 1'b0;
	logic [18:0] periph_out_in = 19'h0_0000;
	logic        spi_four_wire_in = 1'b0;
	logic        serial_a_mode0_in = 1'b0;
	logic [31:0] ext_en = 32'h0000_0000;
	logic [31:0] ext_val = 32'h0000_0000;
	wire  [7:0]  rd_data_out;
	wire         rd_valid_out;
	wire  [18:0] periph_in_out, route_active_out;
	wire  [31:0] pin_level, pin_out_out, pin_oe_out, pin_pullup_out;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          p;
	pxb_row_t    rows [3];
	logic [7:0]  v;
	pxb_crossbar pxb_crossbar_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .wr_en_in(wr_en_in),
		.wr_target_in(wr_target_in), .wr_mask_in(wr_mask_in), .wr_data_in(wr_data_in), .rd_en_in(rd_en_in),
		.rd_target_in(rd_target_in), .rd_rmw_in(rd_rmw_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
		.periph_out_in(periph_out_in), .periph_drive_in(19'h7_FFFF), .spi_four_wire_in(spi_four_wire_in),
		.serial_a_mode0_in(serial_a_mode0_in), .serial_b_mode0_in(1'b0), .small_package_in(1'b0),
		.periph_in_out(periph_in_out), .route_active_out(route_active_out), .pin_level_in(pin_level),
		.pin_out_out(pin_out_out), .pin_oe_out(pin_oe_out), .pin_pullup_out(pin_pullup_out));
	pxb_far_side pxb_far_side_i (.clk_in(clk_in), .pin_out_in(pin_out_out), .pin_oe_in(pin_oe_out),
		.pin_pullup_in(pin_pullup_out), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_level));
	initial
		forever #50 clk_in = ~clk_in;
	// Compares seen against expected.
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic conclude();
		$display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Register write on falling edges.
	task automatic wr(input logic [3:0] t, input logic [7:0] m, input logic [7:0] d);
		wr_target_in = t;
		wr_mask_in = m;
		wr_data_in = d;
		wr_en_in = 1'b1;
		@(negedge clk_in);
		wr_en_in = 1'b0;
		@(negedge clk_in);
	endtask
	// Register read, bounded wait.
	task automatic rd(input logic [3:0] t, input logic m);
		int i;
		rd_target_in = t;
		rd_rmw_in = m;
		rd_en_in = 1'b1;
		@(negedge clk_in);
		rd_en_in = 1'b0;
		for (i = 0; i < 4 && rd_valid_out !== 1'b1; i++)
			@(negedge clk_in);
		if (rd_valid_out !== 1'b1)
		begin
			chk("rd_valid", rd_valid_out, 1'b1);
			conclude();
		end
		v = rd_data_out;
		@(negedge clk_in);
	endtask
	initial
	begin
		rows[0] = '{8'h35, 8'h14, 8'h00, 8'hE3, 8'hFF, 1'b0, 19'h3_FCC3, 32'h0000_6002, 32'h0000_03FD};
		rows[1] = '{8'h02, 8'h00, 8'h04, 8'hFF, 8'hFF, 1'b0, 19'h0_031C, 32'h0000_0010, 32'h0000_000F};
		rows[2] = '{8'h07, 8'h00, 8'h04, 8'h00, 8'h00, 1'b1, 19'h0_03FF, 32'h0200_0002, 32'h0100_00FD};
		repeat (8) @(negedge clk_in);
		reset_n_in = 1'b1;
		chk("pu_rst", pin_pullup_out, 32'hFFFF_FFFF);
		rd(4'h4, 1'b0);
		chk("omode_rst", v, 8'h00);
		rd(4'hA, 1'b0);
		chk("imode_rst", v, 8'hFF);
		rd(4'h8, 1'b0);
		chk("imode_p0", v, 8'h00);
		$display("Reset test done");
		// Crossbar set up first, then enabled.
		foreach (rows[k])
		begin
			spi_four_wire_in = rows[k].fw;
			wr(4'hC, 8'hFF, rows[k].c0);
			wr(4'hD, 8'hFF, rows[k].c1);
			wr(4'hE, 8'hFF, rows[k].c2);
			wr(4'h9, 8'hFF, rows[k].i1);
			wr(4'hA, 8'hFF, rows[k].i2);
			for (p = 4; p < 8; p++)
				wr(p[3:0], 8'hFF, 8'hFF);
			chk("oe_off", pin_oe_out, 32'h0000_0000);
			wr(4'hE, 8'h10, 8'h10);
			chk("route", route_active_out, rows[k].rt);
			chk("oe", pin_oe_out, ~rows[k].ip);
			chk("out", pin_out_out | rows[k].ip, ~rows[k].op);
			$display("Row %0d done", k);
		end
		// Port 3 open-drain, one bit cleared.
		wr(4'h7, 8'hFF, 8'h00);
		wr(4'h3, 8'h80, 8'h00);
		chk("p3_oe", pin_oe_out[31:30], 2'b10);
		chk("p3_pu", pin_pullup_out[31:30], 2'b01);
		chk("an_pu", pin_pullup_out[23:8], 16'h0000);
		periph_out_in = 19'h0_0001;
		wr(4'h0, 8'hFF, 8'h00);
		chk("p0_out", pin_out_out[0], 1'b1);
		$display("Output test done");
		// Port 1 analog pins parked, board drives some pins.
		wr(4'h5, 8'hFF, 8'h00);
		ext_en = 32'h4200_FF00;
		ext_val = 32'h0000_FF00;
		rd(4'h3, 1'b0);
		chk("rd_sync", v[7:6], 2'b01);
		rd(4'h3, 1'b0);
		chk("rd_pin", v[7:6], 2'b00);
		rd(4'h3, 1'b1);
		chk("rd_rmw", v[7:6], 2'b01);
		rd(4'h1, 1'b0);
		chk("rd_an", v, 8'h00);
		chk("rx_b", periph_in_out[9], 1'b0);
		$display("Read test done");
		// Mode-0 receive and two-wire data never drive high.
		serial_a_mode0_in = 1'b1;
		periph_out_in = 19'h0_0043;
		@(negedge clk_in);
		chk("od_hi", {pin_oe_out[6], pin_oe_out[1:0]}, 3'b001);
		periph_out_in = 19'h0_0000;
		@(negedge clk_in);
		chk("od_lo", {pin_oe_out[6], pin_oe_out[1:0]}, 3'b111);
		wr(4'hE, 8'h80, 8'h80);
		chk("pu_off", pin_pullup_out, 32'h0000_0000);
		$display("Mode test done");
		conclude();
	end
endmodule // pxb_crossbar_tb
bind pxb_crossbar pxb_crossbar_checker pxb_crossbar_checker_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
	.wr_en_in(wr_en_in), .wr_target_in(wr_target_in), .wr_mask_in(wr_mask_in), .wr_data_in(wr_data_in),
	.rd_en_in(rd_en_in), .rd_target_in(rd_target_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
	.periph_out_in(periph_out_in), .spi_four_wire_in(spi_four_wire_in), .serial_a_mode0_in(serial_a_mode0_in),
	.periph_in_out(periph_in_out), .route_active_out(route_active_out), .pin_out_out(pin_out_out),
	.pin_oe_out(pin_oe_out));
`default_nettype wire
